// *** logic/pim_pkg.sv ***
// Constants and carrier types for the peripheral interrupt mask block.
// Assumes the processor core decodes the special-function space itself.
package pim_pkg;

  // Register placement and reset value
  localparam logic [7:0] PIM_MASK_ADDR = 8'hE6;
  localparam logic [7:0] PIM_MASK_RESET = 8'h00;
  localparam logic [7:0] PIM_RDATA_IDLE = 8'h00;

  // Number of gated interrupt groups
  localparam int PIM_GROUPS = 8;

  // Enable bit positions inside the mask register
  localparam int PIM_BIT_TIMER_THREE = 7;
  localparam int PIM_BIT_COMPARATOR_ONE = 6;
  localparam int PIM_BIT_COMPARATOR_ZERO = 5;
  localparam int PIM_BIT_COUNTER_ARRAY = 4;
  localparam int PIM_BIT_CONVERSION_DONE = 3;
  localparam int PIM_BIT_WINDOW_COMPARE = 2;
  localparam int PIM_BIT_RTC_ALARM = 1;
  localparam int PIM_BIT_TWOWIRE = 0;

  // Layout of the mask register, bit 7 first
  typedef struct packed {
    logic timer_three_irq_en;
    logic comparator_one_irq_en;
    logic comparator_zero_irq_en;
    logic counter_array_irq_en;
    logic conversion_done_irq_en;
    logic window_compare_irq_en;
    logic rtc_alarm_irq_en;
    logic twowire_irq_en;
  } pim_mask_t;

  // One special-function bus request
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } pim_sfr_req_t;

endpackage : pim_pkg

// *** logic/pim_gate.sv ***
// Per-group gate: forwards a raw request only while its enable is set.
// Assumes raw requests come from logic on the same clock.
`timescale 1ns/1ps
module pim_gate #(
  parameter int WIDTH = 8
) (
  input wire logic clk, // System clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic clk_en, // Freezes state while low
  input wire logic [WIDTH-1:0] raw_req, // Raw per-group requests
  input wire logic [WIDTH-1:0] enable, // Per-group enables
  output logic [WIDTH-1:0] fwd_req // Registered gated requests
);

  ////////////////////////////////////////////////////////////////////////////
  // One registered AND gate per group; the source is only read, never cleared
  for (genvar g = 0; g < WIDTH; g++) begin : g_gate
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        fwd_req[g] <= 1'b0;
      end else if (clk_en) begin
        fwd_req[g] <= raw_req[g] & enable[g];
      end
    end
  end

endmodule : pim_gate

// *** logic/pim_top.sv ***
// Peripheral interrupt mask: one byte-wide special-function register whose
// eight bits gate eight peripheral interrupt groups toward the core.
// Assumes the core presents address and one-cycle strobes on MCLK, and that
// source flags are levels that their own peripherals set and clear.
// Gated requests and read data leave through flops, one cycle after their cause;
// the mask itself comes straight from its flops so the core sees it at once.
// The block never clears a source flag; the owning peripheral does that.
// Nothing here resynchronises inputs: every source already runs on MCLK.
//
// Contract
// - The mask sits at address E6 on every page, all bits read and write, reset to zero.
// - Bit 7 forwards the timer-three low or high overflow requests, else blocks both.
// - Bit 6 forwards comparator one rise or fall requests, else suppresses them.
// - Bit 5 forwards comparator zero rise or fall requests, else suppresses them.
// - Bit 4 forwards any counter-array request, else suppresses all its sources.
// - Bit 3 lets the conversion-done flag raise a request, else masks it.
// - Bit 2 lets the window-compare flag raise a request, else masks it.
// - Bit 1 lets a real-time clock alarm raise a request, else masks it.
// - Bit 0 forwards any SMBus request, else suppresses all SMBus sources.
`timescale 1ns/1ps
module pim_top #(
  parameter int COUNTER_ARRAY_W = 5 // Number of counter-array sources
) (
  input wire logic MCLK, // System clock, 40 MHz
  input wire logic RESET_N, // Asynchronous reset, active low
  input wire logic CLK_EN, // Freezes all state while low
  input wire logic [7:0] SFR_ADDR, // Special-function address
  input wire logic SFR_WR, // Write strobe, one cycle
  input wire logic SFR_RD, // Read strobe, one cycle
  input wire logic [7:0] SFR_WDATA, // Write data
  output logic [7:0] SFR_RDATA, // Read data, registered
  output logic SFR_RHIT, // Read answered by this block, pulse
  input wire logic TIMER_THREE_LOW_OVERFLOW, // Timer three low overflow flag
  input wire logic TIMER_THREE_HIGH_OVERFLOW, // Timer three high overflow flag
  input wire logic COMPARATOR_ONE_RISE_FLAG, // Comparator one rising edge flag
  input wire logic COMPARATOR_ONE_FALL_FLAG, // Comparator one falling edge flag
  input wire logic COMPARATOR_ZERO_RISE_FLAG, // Comparator zero rising edge flag
  input wire logic COMPARATOR_ZERO_FALL_FLAG, // Comparator zero falling edge flag
  input wire logic [COUNTER_ARRAY_W-1:0] COUNTER_ARRAY_REQ, // Counter-array sources
  input wire logic CONVERSION_DONE_FLAG, // Converter conversion complete flag
  input wire logic WINDOW_COMPARE_FLAG, // Converter window compare flag
  input wire logic RTC_ALARM_REQ, // Real-time clock alarm request
  input wire logic TWOWIRE_REQ, // SMBus interrupt request
  output logic [7:0] IRQ_REQ, // Gated requests to the core, registered
  output logic [7:0] IRQ_MASK // Current mask register value
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus request bundle and address decode; page selection is ignored
  pim_pkg::pim_sfr_req_t sfr;
  pim_pkg::pim_mask_t peripheral_irq_mask_reg;
  logic hit;
  logic [7:0] raw_req;

  assign sfr = '{addr: SFR_ADDR, wr: SFR_WR, rd: SFR_RD, wdata: SFR_WDATA};
  assign hit = (sfr.addr == pim_pkg::PIM_MASK_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // Mask register: plain byte write, cleared by reset
  // Frozen cycles and writes to any other address leave the mask as it is
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      peripheral_irq_mask_reg <= pim_pkg::PIM_MASK_RESET;
    end else if (CLK_EN && sfr.wr && hit) begin
      peripheral_irq_mask_reg <= sfr.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path: value before any write in the same cycle, answered one cycle on
  // A read and a write in one cycle return the old byte; the write still lands
  // Read data holds between hits so a slow core can still pick it up late
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      SFR_RDATA <= pim_pkg::PIM_RDATA_IDLE;
      SFR_RHIT <= 1'b0;
    end else if (CLK_EN) begin
      SFR_RHIT <= sfr.rd && hit;
      if (sfr.rd && hit) begin
        SFR_RDATA <= peripheral_irq_mask_reg;
      end
    end
  end

  assign IRQ_MASK = peripheral_irq_mask_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Collapse each peripheral's sources into one raw group request
  // One enable per group, so sources that share a group are ORed first
  always_comb begin
    raw_req = '0;
    raw_req[pim_pkg::PIM_BIT_TIMER_THREE] =
      TIMER_THREE_LOW_OVERFLOW | TIMER_THREE_HIGH_OVERFLOW;
    raw_req[pim_pkg::PIM_BIT_COMPARATOR_ONE] =
      COMPARATOR_ONE_RISE_FLAG | COMPARATOR_ONE_FALL_FLAG;
    raw_req[pim_pkg::PIM_BIT_COMPARATOR_ZERO] =
      COMPARATOR_ZERO_RISE_FLAG | COMPARATOR_ZERO_FALL_FLAG;
    raw_req[pim_pkg::PIM_BIT_COUNTER_ARRAY] = |COUNTER_ARRAY_REQ;
    raw_req[pim_pkg::PIM_BIT_CONVERSION_DONE] = CONVERSION_DONE_FLAG;
    raw_req[pim_pkg::PIM_BIT_WINDOW_COMPARE] = WINDOW_COMPARE_FLAG;
    raw_req[pim_pkg::PIM_BIT_RTC_ALARM] = RTC_ALARM_REQ;
    raw_req[pim_pkg::PIM_BIT_TWOWIRE] = TWOWIRE_REQ;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gating stage: the enables act on the requests, never on the flags
  // Raw levels go in unchanged, so a pending flag reaches the core once enabled
  pim_gate #(
    .WIDTH(pim_pkg::PIM_GROUPS)
  ) u_gate (
    .clk(MCLK),
    .reset_n(RESET_N),
    .clk_en(CLK_EN),
    .raw_req(raw_req),
    .enable(peripheral_irq_mask_reg),
    .fwd_req(IRQ_REQ)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the register
  mask_write_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && SFR_WR && SFR_ADDR == pim_pkg::PIM_MASK_ADDR
      |=> IRQ_MASK == $past(SFR_WDATA))
    else $error("mask did not take written byte");

  mask_hold_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    !(CLK_EN && SFR_WR && SFR_ADDR == pim_pkg::PIM_MASK_ADDR) |=> $stable(IRQ_MASK))
    else $error("mask changed without a write");

  mask_read_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && SFR_RD && SFR_ADDR == pim_pkg::PIM_MASK_ADDR
      |=> SFR_RHIT && SFR_RDATA == $past(IRQ_MASK))
    else $error("mask read returned wrong data");

  ////////////////////////////////////////////////////////////////////////////
  // Checks on each gated group, one cycle after its cause, and on all state frozen while CLK_EN is low
  timer_gate_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN |=> IRQ_REQ[7] == $past(IRQ_MASK[7]
      & (TIMER_THREE_LOW_OVERFLOW | TIMER_THREE_HIGH_OVERFLOW)))
    else $error("timer three gate wrong");

  cmp_one_gate_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN |=> IRQ_REQ[6] == $past(IRQ_MASK[6]
      & (COMPARATOR_ONE_RISE_FLAG | COMPARATOR_ONE_FALL_FLAG)))
    else $error("comparator one gate wrong");

  cmp_zero_gate_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN |=> IRQ_REQ[5] == $past(IRQ_MASK[5]
      & (COMPARATOR_ZERO_RISE_FLAG | COMPARATOR_ZERO_FALL_FLAG)))
    else $error("comparator zero gate wrong");

  counter_gate_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN |=> IRQ_REQ[4] == $past(IRQ_MASK[4] & (|COUNTER_ARRAY_REQ)))
    else $error("counter array gate wrong");

  conv_gate_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN |=> IRQ_REQ[3] == $past(IRQ_MASK[3] & CONVERSION_DONE_FLAG))
    else $error("conversion done gate wrong");

  window_gate_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN |=> IRQ_REQ[2] == $past(IRQ_MASK[2] & WINDOW_COMPARE_FLAG))
    else $error("window compare gate wrong");

  alarm_gate_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN |=> IRQ_REQ[1] == $past(IRQ_MASK[1] & RTC_ALARM_REQ))
    else $error("alarm gate wrong");

  twowire_gate_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN |=> IRQ_REQ[0] == $past(IRQ_MASK[0] & TWOWIRE_REQ))
    else $error("SMBus gate wrong");

  pending_late_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && !IRQ_MASK[3] ##1 CLK_EN && IRQ_MASK[3] && CONVERSION_DONE_FLAG
      |=> IRQ_REQ[3])
    else $error("pending flag not delivered after enable");

  state_freeze_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    !CLK_EN |=> $stable(IRQ_REQ) && $stable(IRQ_MASK) && $stable(SFR_RHIT)
      && $stable(SFR_RDATA))
    else $error("state moved while clock enable low");

  ////////////////////////////////////////////////////////////////////////////
  // Further checks: reset values, read answer, counter group, late enables
  reset_values_a: assert property (@(posedge MCLK)
    !RESET_N ##1 !RESET_N |-> IRQ_MASK == pim_pkg::PIM_MASK_RESET
      && IRQ_REQ == 8'h00 && SFR_RDATA == pim_pkg::PIM_RDATA_IDLE && !SFR_RHIT)
    else $error("outputs not cleared by reset");

  rhit_drop_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && !(SFR_RD && SFR_ADDR == pim_pkg::PIM_MASK_ADDR) |=> !SFR_RHIT)
    else $error("read answer without a read");

  rdata_hold_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    !(CLK_EN && SFR_RD && SFR_ADDR == pim_pkg::PIM_MASK_ADDR) |=> $stable(SFR_RDATA))
    else $error("read data changed without a read");

  counter_any_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && IRQ_MASK[4] && COUNTER_ARRAY_REQ != '0 |=> IRQ_REQ[4])
    else $error("counter array source not forwarded");

  counter_off_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && !IRQ_MASK[4] |=> !IRQ_REQ[4])
    else $error("counter array source leaked");

  pending_timer_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && !IRQ_MASK[7] ##1 CLK_EN && IRQ_MASK[7] && TIMER_THREE_HIGH_OVERFLOW
      |=> IRQ_REQ[7])
    else $error("pending timer flag not delivered after enable");

  pending_cmp_one_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && !IRQ_MASK[6] ##1 CLK_EN && IRQ_MASK[6] && COMPARATOR_ONE_FALL_FLAG
      |=> IRQ_REQ[6])
    else $error("pending comparator flag not delivered after enable");

  pending_window_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && !IRQ_MASK[2] ##1 CLK_EN && IRQ_MASK[2] && WINDOW_COMPARE_FLAG
      |=> IRQ_REQ[2])
    else $error("pending window flag not delivered after enable");

  pending_twowire_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && !IRQ_MASK[0] ##1 CLK_EN && IRQ_MASK[0] && TWOWIRE_REQ
      |=> IRQ_REQ[0])
    else $error("pending SMBus request not delivered after enable");

endmodule : pim_top

// *** sim/pim_core_model.sv ***
// Behavioural model of the processor core beside the mask block.
// Assumes the bench hands it each access at the falling edge of the clock.
`timescale 1ns/1ps
module pim_core_model (
  input wire logic clk, // System clock
  input wire pim_pkg::pim_sfr_req_t next_req, // Access the core issues this cycle
  input wire logic [7:0] irq_req, // Gated requests from the mask block
  output pim_pkg::pim_sfr_req_t req, // Access presented on the register bus
  output int taken // Cycles in which any request was pending
);
  ////////////////////////////////////////////////////////////////////////////
  // Bus access: passed straight through, so strobes last as long as the bench holds them
  always_comb req = next_req;

  ////////////////////////////////////////////////////////////////////////////
  // Service counter: a real core would vector here, we only count
  initial taken = 0;
  always @(posedge clk) begin
    if (|irq_req) taken <= taken + 1;
  end
endmodule : pim_core_model

// *** sim/peripheral_irq_mask_tb.sv ***
// Self-checking bench for the peripheral interrupt mask block.
// Assumes a reference model here and the core model drive and judge every cycle.
`timescale 1ns/1ps
module peripheral_irq_mask_tb;
  logic MCLK, RESET_N, CLK_EN, SFR_RHIT;
  logic [14:0] src;
  logic [7:0] SFR_RDATA, IRQ_REQ, IRQ_MASK;
  logic [31:0] seed, mix;
  pim_pkg::pim_sfr_req_t next_req, req;
  int num_errors, compares, cycles, taken, mask, exp_irq, exp_rdata, exp_rhit;

  ////////////////////////////////////////////////////////////////////////////
  // Clock, 25 ns period
  initial begin
    MCLK = 1'b0;
    forever #12.5 MCLK = ~MCLK;
  end

  pim_core_model core (.clk(MCLK), .next_req(next_req), .irq_req(IRQ_REQ), .req(req),
    .taken(taken));

  pim_top #(.COUNTER_ARRAY_W(5)) DUT (.MCLK(MCLK), .RESET_N(RESET_N), .CLK_EN(CLK_EN),
    .SFR_ADDR(req.addr), .SFR_WR(req.wr), .SFR_RD(req.rd), .SFR_WDATA(req.wdata),
    .SFR_RDATA(SFR_RDATA), .SFR_RHIT(SFR_RHIT), .TIMER_THREE_LOW_OVERFLOW(src[14]),
    .TIMER_THREE_HIGH_OVERFLOW(src[13]), .COMPARATOR_ONE_RISE_FLAG(src[12]),
    .COMPARATOR_ONE_FALL_FLAG(src[11]), .COMPARATOR_ZERO_RISE_FLAG(src[10]),
    .COMPARATOR_ZERO_FALL_FLAG(src[9]), .COUNTER_ARRAY_REQ(src[8:4]),
    .CONVERSION_DONE_FLAG(src[3]), .WINDOW_COMPARE_FLAG(src[2]), .RTC_ALARM_REQ(src[1]),
    .TWOWIRE_REQ(src[0]), .IRQ_REQ(IRQ_REQ), .IRQ_MASK(IRQ_MASK));

  // Pseudo-random step and source grouping
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic [7:0] groups(input logic [14:0] s);
    return {s[14] | s[13], s[12] | s[11], s[10] | s[9], |s[8:4], s[3:0]};
  endfunction : groups

  ////////////////////////////////////////////////////////////////////////////
  // Reference model: old mask gates requests and answers reads
  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mask = 0; exp_irq = 0; exp_rdata = 0; exp_rhit = 0;
    end else if (CLK_EN) begin
      exp_irq = groups(src) & mask;
      exp_rhit = int'(req.rd && req.addr == pim_pkg::PIM_MASK_ADDR);
      if (exp_rhit != 0) exp_rdata = mask;
      if (req.wr && req.addr == pim_pkg::PIM_MASK_ADDR) mask = req.wdata;
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("num_errors %0d compares %0d serviced %0d", num_errors, compares, taken);
    if (num_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////
  // Every cycle, once outputs settle, compare with the model; bound the run
  always @(posedge MCLK) begin
    #2;
    cycles++;
    check(IRQ_MASK, 8'(mask));
    check(IRQ_REQ & 8'hF0, 8'(exp_irq) & 8'hF0);
    check(IRQ_REQ & 8'h0F, 8'(exp_irq) & 8'h0F);
    check(IRQ_REQ, 8'(exp_irq));
    check({7'h00, SFR_RHIT}, 8'(exp_rhit));
    check(SFR_RDATA, 8'(exp_rdata));
    if (cycles > 6000) begin
      num_errors++;
      end_of_test();
    end
  end

  // One bus cycle plus source levels, launched at the falling edge
  task automatic drive(input logic en, input logic [7:0] a, input logic w, input logic r,
    input logic [7:0] d, input logic [14:0] s);
    @(negedge MCLK);
    CLK_EN <= en;
    next_req <= '{addr: a, wr: w, rd: r, wdata: d};
    src <= s;
  endtask : drive

  ////////////////////////////////////////////////////////////////////////////
  // Directed cases first, then random traffic with a reset in mid-run
  initial begin
    RESET_N = 1'b0; CLK_EN = 1'b1; src = '0; next_req = '0; seed = 32'hDD7F;
    repeat (5) @(negedge MCLK);
    RESET_N <= 1'b1;
    drive(1'b1, 8'hE6, 1'b1, 1'b0, 8'hA5, 15'h0000);
    drive(1'b1, 8'hE6, 1'b0, 1'b1, 8'h00, 15'h0000);
    drive(1'b1, 8'h12, 1'b1, 1'b1, 8'hFF, 15'h0000);
    drive(1'b1, 8'hE6, 1'b1, 1'b1, 8'h00, 15'h7FFF);
    repeat (3) drive(1'b1, 8'h00, 1'b0, 1'b0, 8'h00, 15'h7FFF);
    for (int g = 0; g < 8; g++) begin
      drive(1'b1, 8'hE6, 1'b1, 1'b0, 8'(1 << g), 15'h7FFF);
      drive(1'b1, 8'hE6, 1'b0, 1'b1, 8'h00, 15'h7FFF);
      drive(1'b0, 8'hE6, 1'b0, 1'b1, 8'h00, 15'h7FFF);
    end
    for (int i = 0; i < 1500; i++) begin
      seed = lfsr(seed);
      mix = lfsr(seed ^ 32'h5A5A);
      drive(|seed[2:0], seed[3] ? 8'hE6 : seed[15:8], seed[4], seed[5], seed[23:16],
        mix[14:0]);
      if (i == 700) RESET_N <= 1'b0;
      if (i == 702) RESET_N <= 1'b1;
    end
    repeat (3) @(negedge MCLK);
    end_of_test();
  end
endmodule : peripheral_irq_mask_tb
